// [hw/status_slave.sv]
// command interpreter for the burner status bus slave
// Function
// - only function codes 02, 03, 04, 06 and 10 are accepted, all others are unsupported.
// - code 02 reads discrete inputs and returns them bit packed.
// - codes 03 and 04 return two bytes for every requested register.
// - frames carry an offset from the command's base address, not the address itself.
// - status bits are positive logic, on reads as 1 and off as 0.
// - a latched bit copies its live bit but stays set until the system restarts.
// - discrete inputs are single read-only bits with no write path.
// - reading one discrete input returns one byte, value in bit 0, other bits zero.
// - several discrete inputs are packed from bit 0 upward, unused bits zero.
// - the run bit is set in every controller state except ready, alarm and shutdown.
// - the run bit is also set while waiting to relight and in manual operation.
// - offset 1 shows the ignition valve drive command.
// - offset 2 shows the low flame valve drive command.
// - offset 3 shows the high flame valve drive command.
`timescale 1ns/1ps
`include "slave_params.svh"

module status_slave #(
  parameter logic [7:0] SLAVE_ADDR = 8'h01,
  parameter int         HOLD_DEPTH = 16
) (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   rx_valid,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   rx_end,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output logic [7:0]                  tx_data,
  output logic                        tx_last,
  input  wire slave_pkg::ctrl_state_t ctrl_state,
  input  wire logic                   relight_wait,
  input  wire logic                   manual_mode,
  input  wire logic                   pilot_drive,
  input  wire logic                   low_drive,
  input  wire logic                   high_drive,
  input  wire logic                   sys_restart
);

  localparam int HW = (HOLD_DEPTH > 1) ? $clog2(HOLD_DEPTH) : 1;

  typedef struct packed {
    slave_pkg::link_state_t         st;
    logic                           addr_ok;
    logic [7:0]                     cnt;
    logic [7:0]                     func;
    logic [15:0]                    off;
    logic [15:0]                    qty;
    logic [7:0]                     bcnt;
    logic [7:0]                     hi;
    logic [15:0]                    wptr;
    logic [7:0]                     exc;
    logic [7:0]                     len;
    logic [7:0]                     idx;
    logic [7:0]                     data;
    logic                           valid;
    logic [15:0]                    frames;
    logic [HOLD_DEPTH-1:0][15:0]    hold;
  } slave_t;

  slave_t              slave_r;
  slave_t              slave_nxt;
  logic [`DI_COUNT-1:0] di_vec;
  logic                supported;
  logic [16:0]         span;
  logic [16:0]         limit;
  logic                range_ok;
  logic                count_ok;
  logic                body_ok;
  logic                answer;
  logic [7:0]          exc_code;
  logic [7:0]          resp_len;
  logic                wr_many_ok;
  logic [HW-1:0]       wr_idx;
  logic [7:0]          nidx;
  logic [7:0]          kk;
  logic [15:0]         rd_w;
  logic [15:0]         rd_word;
  logic [7:0]          packed_byte;
  logic [7:0]          next_byte;

  burner_status u_status (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .ctrl_state   (ctrl_state),
    .relight_wait (relight_wait),
    .manual_mode  (manual_mode),
    .pilot_drive  (pilot_drive),
    .low_drive    (low_drive),
    .high_drive   (high_drive),
    .sys_restart  (sys_restart),
    .di_vec       (di_vec)
  );

  di_byte_packer #(
    .N (`DI_COUNT)
  ) u_packer (
    .vec      (di_vec),
    .start    (slave_r.off),
    .qty      (slave_r.qty),
    .byte_idx (kk),
    .data     (packed_byte)
  );

  // request decode
  assign supported = (slave_r.func == `FC_READ_DI) ||
                     (slave_r.func == `FC_READ_HOLD) ||
                     (slave_r.func == `FC_READ_INREG) ||
                     (slave_r.func == `FC_WRITE_ONE) ||
                     (slave_r.func == `FC_WRITE_MANY);

  assign span = 17'(slave_r.off) + 17'(slave_r.qty);

  always_comb begin
    if (slave_r.func == `FC_READ_DI) begin
      limit = 17'(`DI_COUNT);
    end else if (slave_r.func == `FC_READ_INREG) begin
      limit = 17'(`INREG_COUNT);
    end else begin
      limit = 17'(HOLD_DEPTH);
    end
  end

  always_comb begin
    if (slave_r.func == `FC_WRITE_ONE) begin
      range_ok = 17'(slave_r.off) < 17'(HOLD_DEPTH);
    end else begin
      range_ok = (slave_r.qty != 16'h0000) && (span <= limit);
    end
  end

  // two bytes per written register
  assign count_ok = (slave_r.func != `FC_WRITE_MANY) ||
                    (17'(slave_r.bcnt) == {slave_r.qty, 1'b0});

  always_comb begin
    if (slave_r.func == `FC_WRITE_MANY) begin
      body_ok = 17'(slave_r.cnt) == 17'(`DATA_START) + 17'(slave_r.bcnt);
    end else begin
      body_ok = slave_r.cnt == `REQ_LEN;
    end
  end

  assign answer = slave_r.addr_ok && (slave_r.cnt >= 8'h02) && (!supported || body_ok);

  always_comb begin
    if (!supported) begin
      exc_code = `EXC_BAD_FUNC;
    end else if (!range_ok) begin
      exc_code = `EXC_BAD_ADDR;
    end else if (!count_ok) begin
      exc_code = `EXC_BAD_VALUE;
    end else begin
      exc_code = `EXC_NONE;
    end
  end

  always_comb begin
    if (exc_code != `EXC_NONE) begin
      resp_len = `EXC_LEN;
    end else if (slave_r.func == `FC_READ_DI) begin
      resp_len = `HDR_LEN + 8'((slave_r.qty + 16'h0007) >> 3);
    end else if ((slave_r.func == `FC_READ_HOLD) || (slave_r.func == `FC_READ_INREG)) begin
      resp_len = `HDR_LEN + {slave_r.qty[6:0], 1'b0};
    end else begin
      resp_len = `ECHO_LEN;
    end
  end

  // streaming write of code 10 data words
  assign wr_many_ok = slave_r.addr_ok && (slave_r.func == `FC_WRITE_MANY) && count_ok &&
                      (slave_r.wptr < slave_r.qty) &&
                      (17'(slave_r.off) + 17'(slave_r.wptr) < 17'(HOLD_DEPTH));
  assign wr_idx = HW'(slave_r.off + slave_r.wptr);

  // response byte builder
  assign nidx = slave_r.idx + 8'h01;
  assign kk   = nidx - `HDR_LEN;

  always_comb begin
    rd_w = slave_r.off + 16'(kk[7:1]);
    if (slave_r.func == `FC_READ_INREG) begin
      rd_word = (rd_w == `INREG_STATUS) ? 16'(di_vec) : slave_r.frames;
    end else begin
      rd_word = slave_r.hold[rd_w[HW-1:0]];
    end
  end

  always_comb begin
    next_byte = 8'h00;
    if (nidx == 8'h01) begin
      next_byte = (slave_r.exc != `EXC_NONE) ? (slave_r.func | `FC_EXC_FLAG) : slave_r.func;
    end else if (slave_r.exc != `EXC_NONE) begin
      next_byte = slave_r.exc;
    end else if (slave_r.func == `FC_READ_DI) begin
      next_byte = (nidx == 8'h02) ? slave_r.len - `HDR_LEN : packed_byte;
    end else if ((slave_r.func == `FC_READ_HOLD) || (slave_r.func == `FC_READ_INREG)) begin
      if (nidx == 8'h02) begin
        next_byte = slave_r.len - `HDR_LEN;
      end else begin
        next_byte = kk[0] ? rd_word[7:0] : rd_word[15:8];
      end
    end else begin
      case (nidx)
        8'h02:   next_byte = slave_r.off[15:8];
        8'h03:   next_byte = slave_r.off[7:0];
        8'h04:   next_byte = slave_r.qty[15:8];
        default: next_byte = slave_r.qty[7:0];
      endcase
    end
  end

  always_comb begin
    slave_nxt = slave_r;
    unique case (slave_r.st)
      slave_pkg::ST_IDLE, slave_pkg::ST_RX: begin
        if (rx_valid) begin
          slave_nxt.st  = slave_pkg::ST_RX;
          slave_nxt.cnt = (slave_r.cnt == 8'hff) ? 8'hff : slave_r.cnt + 8'h01;
          case (slave_r.cnt)
            8'h00: slave_nxt.addr_ok = (rx_data == SLAVE_ADDR);
            8'h01: slave_nxt.func = rx_data;
            8'h02: slave_nxt.off[15:8] = rx_data;
            8'h03: slave_nxt.off[7:0] = rx_data;
            8'h04: slave_nxt.qty[15:8] = rx_data;
            8'h05: slave_nxt.qty[7:0] = rx_data;
            8'h06: slave_nxt.bcnt = rx_data;
            default: begin
              if (slave_r.cnt[0]) begin
                slave_nxt.hi = rx_data;
              end else if (wr_many_ok) begin
                slave_nxt.hold[wr_idx] = {slave_r.hi, rx_data};
                slave_nxt.wptr = slave_r.wptr + 16'h0001;
              end
            end
          endcase
        end else if (rx_end && (slave_r.st == slave_pkg::ST_RX)) begin
          if (answer) begin
            slave_nxt.st     = slave_pkg::ST_TX;
            slave_nxt.exc    = exc_code;
            slave_nxt.len    = resp_len;
            slave_nxt.idx    = 8'h00;
            slave_nxt.data   = SLAVE_ADDR;
            slave_nxt.valid  = 1'b1;
            slave_nxt.frames = slave_r.frames + 16'h0001;
            // discrete inputs have no write path
            if ((slave_r.func == `FC_WRITE_ONE) && (exc_code == `EXC_NONE)) begin
              slave_nxt.hold[slave_r.off[HW-1:0]] = slave_r.qty;
            end
          end else begin
            slave_nxt.st = slave_pkg::ST_DONE;
          end
        end
      end
      slave_pkg::ST_TX: begin
        if (tx_ready) begin
          if (slave_r.idx == slave_r.len - 8'h01) begin
            slave_nxt.st    = slave_pkg::ST_DONE;
            slave_nxt.valid = 1'b0;
          end else begin
            slave_nxt.idx  = nidx;
            slave_nxt.data = next_byte;
          end
        end
      end
      slave_pkg::ST_DONE: begin
        slave_nxt.st      = slave_pkg::ST_IDLE;
        slave_nxt.cnt     = 8'h00;
        slave_nxt.wptr    = 16'h0000;
        slave_nxt.addr_ok = 1'b0;
        slave_nxt.exc     = `EXC_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slave_r      <= '0;
      slave_r.hold <= {HOLD_DEPTH{`HOLD_RESET}};
    end else begin
      slave_r <= slave_nxt;
    end
  end

  assign tx_valid = slave_r.valid;
  assign tx_data  = slave_r.data;
  assign tx_last  = slave_r.valid && (slave_r.idx == slave_r.len - 8'h01);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence bad_func_end_s;
    rx_end && !rx_valid && (slave_r.st == slave_pkg::ST_RX) &&
    slave_r.addr_ok && (slave_r.cnt >= 8'h02) && !supported;
  endsequence

  sequence exc_reply_s;
    (slave_r.st == slave_pkg::ST_TX) && (slave_r.exc == `EXC_BAD_FUNC) &&
    (slave_r.len == `EXC_LEN) && (slave_r.idx == 8'h00) && tx_valid && (tx_data == SLAVE_ADDR);
  endsequence

  sequence byte_taken_s;
    tx_valid && tx_ready && !tx_last;
  endsequence

  accept_set_a: assert property (
    (tx_valid && (slave_r.exc == `EXC_NONE)) |->
      slave_r.func inside {`FC_READ_DI, `FC_READ_HOLD, `FC_READ_INREG,
                           `FC_WRITE_ONE, `FC_WRITE_MANY})
    else $error("normal reply to an unsupported function");

  bad_func_reply_a: assert property (
    bad_func_end_s |=> exc_reply_s)
    else $error("unsupported function not answered with exception");

  exc_byte_a: assert property (
    (exc_reply_s ##0 tx_ready ##1 tx_ready) |=> (tx_data == `EXC_BAD_FUNC) && tx_last)
    else $error("exception code byte wrong");

  byte_step_a: assert property (
    byte_taken_s |=> tx_valid && (slave_r.idx == $past(slave_r.idx) + 8'h01))
    else $error("response index did not advance");

  word_count_a: assert property (
    (tx_valid && (slave_r.exc == `EXC_NONE) &&
     ((slave_r.func == `FC_READ_HOLD) || (slave_r.func == `FC_READ_INREG))) |->
      (slave_r.len == `HDR_LEN + {slave_r.qty[6:0], 1'b0}))
    else $error("register read length not two bytes per register");

  write_one_a: assert property (
    (rx_end && !rx_valid && (slave_r.st == slave_pkg::ST_RX) && answer &&
     (exc_code == `EXC_NONE) && (slave_r.func == `FC_WRITE_ONE)) |=>
      (slave_r.hold[$past(slave_r.off[HW-1:0])] == $past(slave_r.qty)))
    else $error("single write missed its offset");

  di_readonly_a: assert property (
    ((slave_r.st == slave_pkg::ST_RX) && (slave_r.func == `FC_READ_DI)) |=>
      $stable(slave_r.hold))
    else $error("discrete read changed holding registers");

  single_byte_a: assert property (
    (tx_valid && (slave_r.exc == `EXC_NONE) && (slave_r.func == `FC_READ_DI) &&
     (slave_r.qty == 16'h0001) && (slave_r.idx == `HDR_LEN)) |->
      (tx_data[7:1] == 7'h00) && tx_last)
    else $error("single discrete read not one clean byte");

  pad_zero_a: assert property (
    (tx_last && (slave_r.exc == `EXC_NONE) && (slave_r.func == `FC_READ_DI) &&
     (slave_r.qty[2:0] != 3'h0)) |->
      ((tx_data >> slave_r.qty[2:0]) == 8'h00))
    else $error("unused discrete bits not zero");

endmodule // status_slave

// [hw/slave_params.svh]
// constants shared by the status slave design
`ifndef SLAVE_PARAMS_SVH
`define SLAVE_PARAMS_SVH

// supported function codes
`define FC_READ_DI      8'h02
`define FC_READ_HOLD    8'h03
`define FC_READ_INREG   8'h04
`define FC_WRITE_ONE    8'h06
`define FC_WRITE_MANY   8'h10
`define FC_EXC_FLAG     8'h80

// exception codes
`define EXC_NONE        8'h00
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_ADDR    8'h02
`define EXC_BAD_VALUE   8'h03

// base addresses, subtracted by the master before framing
`define BASE_DI         10001
`define BASE_INREG      30001
`define BASE_HOLD       40001

// discrete input offsets
`define OFF_RUN         0
`define OFF_IGN         1
`define OFF_LOW         2
`define OFF_HIGH        3
`define OFF_LATCH       4
`define DI_LIVE         4
`define DI_COUNT        8

// input register offsets
`define INREG_STATUS    16'h0000
`define INREG_FRAMES    16'h0001
`define INREG_COUNT     2

// reset values and frame lengths
`define HOLD_RESET      16'h0000
`define HDR_LEN         8'h03
`define EXC_LEN         8'h03
`define ECHO_LEN        8'h06
`define REQ_LEN         8'h06
`define DATA_START      8'h07

`endif

// [hw/slave_pkg.sv]
// types shared by the status slave design
package slave_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX   = 2'b01,
    ST_TX   = 2'b11,
    ST_DONE = 2'b10
  } link_state_t;

  typedef enum logic [2:0] {
    CTRL_READY    = 3'h0,
    CTRL_ALARM    = 3'h1,
    CTRL_SHUTDOWN = 3'h2,
    CTRL_PURGE    = 3'h3,
    CTRL_IGNITE   = 3'h4,
    CTRL_FIRING   = 3'h5
  } ctrl_state_t;

endpackage

// [hw/burner_status.sv]
// live and latched burner status bits
`timescale 1ns/1ps
`include "slave_params.svh"

module burner_status (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire slave_pkg::ctrl_state_t ctrl_state,
  input  wire logic                   relight_wait,
  input  wire logic                   manual_mode,
  input  wire logic                   pilot_drive,
  input  wire logic                   low_drive,
  input  wire logic                   high_drive,
  input  wire logic                   sys_restart,
  output logic [`DI_COUNT-1:0]        di_vec
);

  typedef struct packed {
    logic [`DI_LIVE-1:0] live;
    logic [`DI_LIVE-1:0] latched;
  } status_t;

  status_t status_r;
  status_t status_nxt;
  logic    idle_state;

  assign idle_state = (ctrl_state == slave_pkg::CTRL_READY) ||
                      (ctrl_state == slave_pkg::CTRL_ALARM) ||
                      (ctrl_state == slave_pkg::CTRL_SHUTDOWN);

  always_comb begin
    status_nxt = status_r;
    status_nxt.live[`OFF_RUN]  = !idle_state || relight_wait || manual_mode;
    status_nxt.live[`OFF_IGN]  = pilot_drive;
    status_nxt.live[`OFF_LOW]  = low_drive;
    status_nxt.live[`OFF_HIGH] = high_drive;
    // set wins over the restart clear
    status_nxt.latched = status_nxt.live | (sys_restart ? '0 : status_r.latched);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign di_vec = {status_r.latched, status_r.live};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  run_bit_a: assert property (
    ##1 (status_r.live[`OFF_RUN] ==
         $past(!idle_state || relight_wait || manual_mode)))
    else $error("run bit does not follow controller state");

  valve_bits_a: assert property (
    ##1 (status_r.live[`OFF_HIGH:`OFF_IGN] == $past({high_drive, low_drive, pilot_drive})))
    else $error("valve drive bits do not follow drive");

  latch_hold_a: assert property (
    (status_r.latched[`OFF_RUN] && !sys_restart) |=> status_r.latched[`OFF_RUN])
    else $error("latched bit dropped without restart");

endmodule // burner_status

// [hw/di_byte_packer.sv]
// packs discrete inputs into one response byte
`timescale 1ns/1ps

module di_byte_packer #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] vec,
  input  wire logic [15:0]  start,
  input  wire logic [15:0]  qty,
  input  wire logic [7:0]   byte_idx,
  output logic [7:0]        data
);

  localparam int IW = (N > 1) ? $clog2(N) : 1;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic [16:0] n;
      logic [16:0] pos;
      assign n   = 17'({byte_idx, 3'(i)});
      assign pos = 17'(start) + n;
      // lsb first, unused bits zero
      assign data[i] = (n < 17'(qty)) && (pos < 17'(N)) ? vec[pos[IW-1:0]] : 1'b0;
    end
  endgenerate

endmodule // di_byte_packer

// [test/bus_master_model.sv]
// bus master model: sends request frames and takes response bytes
`timescale 1ns/1ps
`include "slave_params.svh"

module bus_master_model (
  input  wire logic       sys_clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic slow;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_end   = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // one frame out, then collect bytes; empty queue when nothing answers
  task automatic transact(input logic [7:0] req[$], output logic [7:0] rsp[$]);
    int n;
    bit fin;
    rsp = {};
    foreach (req[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= req[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~req[req.size()-1];
    rx_end   <= 1'b1;
    @(posedge sys_clk);
    rx_end   <= 1'b0;
    tx_ready <= 1'b1;
    n = 0;
    fin = 1'b0;
    while (!fin && n < 64) begin
      @(posedge sys_clk);
      if (tx_valid && tx_ready) begin
        rsp.push_back(tx_data);
        fin = tx_last;
      end
      if (!fin) tx_ready <= slow ? ~tx_ready : 1'b1;
      n++;
    end
    tx_ready <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // offset framing and two data bytes per written register
  task automatic request(input logic [7:0] fc, input int addr, input int base,
                         input logic [15:0] qv, input logic [15:0] data[$],
                         output logic [7:0] rsp[$]);
    logic [15:0] off;
    logic [7:0]  req[$];
    off = 16'(addr - base);
    req = {8'h01, fc, off[15:8], off[7:0], qv[15:8], qv[7:0]};
    if (fc == `FC_WRITE_MANY) begin
      req.push_back(8'(2 * data.size()));
      foreach (data[i]) req = {req, data[i][15:8], data[i][7:0]};
    end
    transact(req, rsp);
  endtask
endmodule // bus_master_model

// [test/status_slave_tb.sv]
// self-checking bench for the burner status bus slave
`timescale 1ns/1ps
`include "slave_params.svh"

module status_slave_tb;
  logic                   sys_clk      = 1'b0;
  logic                   resetn       = 1'b0;
  logic                   rx_valid;
  logic                   rx_end;
  logic                   tx_valid;
  logic                   tx_ready;
  logic                   tx_last;
  logic [7:0]             rx_data;
  logic [7:0]             tx_data;
  slave_pkg::ctrl_state_t ctrl_state   = slave_pkg::CTRL_READY;
  logic                   relight_wait = 1'b0;
  logic                   manual_mode  = 1'b0;
  logic                   pilot_drive  = 1'b0;
  logic                   low_drive    = 1'b0;
  logic                   high_drive   = 1'b0;
  logic                   sys_restart  = 1'b0;
  int                     mismatches   = 0;
  int                     num_checks   = 0;
  int                     cycles       = 0;
  logic [7:0]             rsp[$];
  logic [15:0]            wd[$];

  always #12.5 sys_clk = ~sys_clk;

  status_slave dut_u (.sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .ctrl_state(ctrl_state),
    .relight_wait(relight_wait), .manual_mode(manual_mode), .pilot_drive(pilot_drive),
    .low_drive(low_drive), .high_drive(high_drive), .sys_restart(sys_restart));

  bus_master_model mst_u (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp(input string what, input logic [7:0] exp[$]);
    check({what, " length"}, 16'(rsp.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < rsp.size()) check(what, {8'h00, rsp[i]}, {8'h00, exp[i]});
    end
  endtask

  task automatic go(input logic [7:0] fc, input int addr, input int base, input logic [15:0] q);
    mst_u.request(fc, addr, base, q, wd, rsp);
  endtask

  // status inputs change at an edge, then settle through the status register
  task automatic set_in(input logic [2:0] st, input logic rw, input logic mm,
                        input logic [2:0] valves);
    @(posedge sys_clk);
    ctrl_state   <= slave_pkg::ctrl_state_t'(st);
    relight_wait <= rw;
    manual_mode  <= mm;
    {high_drive, low_drive, pilot_drive} <= valves;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic restart();
    @(posedge sys_clk);
    sys_restart <= 1'b1;
    @(posedge sys_clk);
    sys_restart <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic t_unsupported();
    logic [7:0] codes[6] = '{8'h01, 8'h05, 8'h07, 8'h0f, 8'h11, 8'h2b};
    foreach (codes[i]) begin
      go(codes[i], 0, 0, 16'h0001);
      cmp("bad func", {8'h01, codes[i] | `FC_EXC_FLAG, `EXC_BAD_FUNC});
    end
  endtask

  task automatic t_run_bit();
    logic [7:0] e;
    for (int s = 0; s < 8; s++) begin
      set_in(s < 6 ? 3'(s) : 3'h0, s == 6, s == 7, 3'h0);
      e = (s >= 3) ? 8'h01 : 8'h00;
      go(`FC_READ_DI, `BASE_DI, `BASE_DI, 16'h0001);
      cmp("run bit", {8'h01, `FC_READ_DI, 8'h01, e});
    end
  endtask

  task automatic t_valves();
    logic [7:0] e;
    for (int v = 0; v < 8; v++) begin
      set_in(3'h5, 1'b0, 1'b0, 3'(v));
      e = {4'h0, 3'(v), 1'b1};
      go(`FC_READ_DI, `BASE_DI, `BASE_DI, 16'h0004);
      cmp("valve bits", {8'h01, `FC_READ_DI, 8'h01, e});
      e = {7'h00, v[2]};
      go(`FC_READ_DI, `BASE_DI + 3, `BASE_DI, 16'h0001);
      cmp("high single", {8'h01, `FC_READ_DI, 8'h01, e});
    end
  endtask

  task automatic t_latch();
    set_in(3'h0, 1'b0, 1'b0, 3'h0);
    restart();
    go(`FC_READ_DI, `BASE_DI, `BASE_DI, 16'h0008);
    cmp("after restart", {8'h01, `FC_READ_DI, 8'h01, 8'h00});
    set_in(3'h0, 1'b0, 1'b0, 3'h1);
    set_in(3'h0, 1'b0, 1'b0, 3'h0);
    go(`FC_READ_DI, `BASE_DI, `BASE_DI, 16'h0008);
    cmp("latched pilot", {8'h01, `FC_READ_DI, 8'h01, 8'h20});
    go(`FC_READ_DI, `BASE_DI + 5, `BASE_DI, 16'h0001);
    cmp("latched single", {8'h01, `FC_READ_DI, 8'h01, 8'h01});
    restart();
    go(`FC_READ_DI, `BASE_DI, `BASE_DI, 16'h0008);
    cmp("latch cleared", {8'h01, `FC_READ_DI, 8'h01, 8'h00});
  endtask

  task automatic t_regs();
    logic [7:0] none[$];
    go(`FC_READ_HOLD, `BASE_HOLD + 5, `BASE_HOLD, 16'h0001);
    cmp("hold reset", {8'h01, `FC_READ_HOLD, 8'h02, 8'h00, 8'h00});
    go(`FC_WRITE_ONE, `BASE_HOLD + 2, `BASE_HOLD, 16'h1234);
    cmp("write one", {8'h01, `FC_WRITE_ONE, 8'h00, 8'h02, 8'h12, 8'h34});
    mst_u.slow = 1'b1;
    wd = {16'habcd, 16'h0102};
    go(`FC_WRITE_MANY, `BASE_HOLD, `BASE_HOLD, 16'h0002);
    cmp("write many", {8'h01, `FC_WRITE_MANY, 8'h00, 8'h00, 8'h00, 8'h02});
    wd = {};
    go(`FC_READ_HOLD, `BASE_HOLD, `BASE_HOLD, 16'h0003);
    cmp("read hold", {8'h01, `FC_READ_HOLD, 8'h06, 8'hab, 8'hcd, 8'h01, 8'h02,
                      8'h12, 8'h34});
    mst_u.slow = 1'b0;
    go(`FC_READ_HOLD, `BASE_HOLD + 16, `BASE_HOLD, 16'h0001);
    cmp("hold range", {8'h01, `FC_READ_HOLD | `FC_EXC_FLAG, `EXC_BAD_ADDR});
    set_in(3'h0, 1'b0, 1'b0, 3'h1);
    go(`FC_READ_INREG, `BASE_INREG, `BASE_INREG, 16'h0001);
    cmp("input reg", {8'h01, `FC_READ_INREG, 8'h02, 8'h00, 8'h22});
    mst_u.transact({8'h02, `FC_READ_HOLD, 8'h00, 8'h00, 8'h00, 8'h01}, rsp);
    none = {};
    cmp("other slave", none);
    mst_u.transact({8'h01, `FC_READ_HOLD, 8'h00, 8'h00, 8'h00}, rsp);
    cmp("short frame", none);
    wd = {16'h5555};
    go(`FC_WRITE_MANY, `BASE_HOLD, `BASE_HOLD, 16'h0002);
    cmp("short count", {8'h01, `FC_WRITE_MANY | `FC_EXC_FLAG, `EXC_BAD_VALUE});
    wd = {};
    go(`FC_READ_HOLD, `BASE_HOLD, `BASE_HOLD, 16'h0001);
    cmp("hold kept", {8'h01, `FC_READ_HOLD, 8'h02, 8'hab, 8'hcd});
    go(`FC_READ_DI, `BASE_DI, `BASE_DI, 16'h0000);
    cmp("zero qty", {8'h01, `FC_READ_DI | `FC_EXC_FLAG, `EXC_BAD_ADDR});
    // answered frames so far, this one included
    go(`FC_READ_INREG, `BASE_INREG + 1, `BASE_INREG, 16'h0001);
    cmp("frame count", {8'h01, `FC_READ_INREG, 8'h02, 8'h00, 8'h2c});
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_unsupported();
    t_run_bit();
    t_valves();
    t_latch();
    t_regs();
    give_verdict();
  end
endmodule // status_slave_tb
